// File: logic/pmsq_cfg.svh
// Purpose: Command codes, field positions, reset values for the supply command block
// Assumes: Included by the package file by bare name; design files see it through that
// Notes:   Definitions only
`ifndef PMSQ_CFG_SVH
`define PMSQ_CFG_SVH

`define PMSQ_NFLT          8
`define PMSQ_CMD_PAGE      8'h00
`define PMSQ_CMD_OPER      8'h01
`define PMSQ_CMD_ONOFF     8'h02
`define PMSQ_CMD_CLRF      8'h03
`define PMSQ_CMD_WLOCK     8'h10
`define PMSQ_CMD_STALL     8'h11
`define PMSQ_CMD_SINGLE    8'hfc
`define PMSQ_PAGE_ALL      8'hff
`define PMSQ_WL_ONLY_WL    8'h80
`define PMSQ_WL_OP_PAGE    8'h40
`define PMSQ_WL_ONOFF      8'h20
`define PMSQ_WL_NONE       8'h00
`define PMSQ_OP_OFF_NOW    8'h00
`define PMSQ_OP_OFF_SOFT   8'h40
`define PMSQ_OP_ON         8'h80
`define PMSQ_OP_MLO_IGN    8'h94
`define PMSQ_OP_MLO_ACT    8'h98
`define PMSQ_OP_MHI_IGN    8'ha4
`define PMSQ_OP_MHI_ACT    8'ha8
`define PMSQ_OP_SEL_PRI    2'h1
`define PMSQ_OP_SEL_SEC    2'h2
`define PMSQ_OP_ON_BIT     7
`define PMSQ_OP_SOFT_BIT   6
`define PMSQ_CFG_USE_CMD   4
`define PMSQ_CFG_OP_EN     3
`define PMSQ_CFG_CTL_EN    2
`define PMSQ_CFG_CTL_POL   1
`define PMSQ_CFG_CTL_FAST  0
`define PMSQ_ONOFF_RST     5'h1e
`define PMSQ_WLOCK_RST     8'h00

`endif

// File: logic/pmsq_pkg.sv
// Purpose: Shared types of the supply command block
// Assumes: pmsq_cfg.svh gives the constants
// Notes:   Carriers are packed structs
`include "pmsq_cfg.svh"
package pmsq_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } pmsq_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } pmsq_resp_t;

   typedef enum logic [1:0] {
      PMSQ_ST_IDLE = 2'b00,
      PMSQ_ST_REQ  = 2'b01
   } pmsq_store_st_t;

   typedef struct packed {
      pmsq_store_st_t st;
      logic           all;
      logic           done;
      logic           fail;
   } pmsq_store_t;
endpackage

// File: logic/pmsq_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   First stage is read only by the second
module pmsq_sync
   import pmsq_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         clk,   // System clock
   input  wire logic         rst_b, // Async reset, active low
   input  wire logic [W-1:0] din,   // Raw pin levels
   output logic      [W-1:0] dout   // Synchronised levels
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end
   assign dout = sync_q;
endmodule

// File: logic/pmsq_store.sv
// Purpose: Flash store sequencer for full and single configuration saves
// Assumes: Flash controller answers flash_ack with flash_err on the same cycle
// Notes:   done and fail are one-cycle pulses
module pmsq_store
   import pmsq_pkg::*;
(
   input  wire logic clk,       // System clock
   input  wire logic rst_b,     // Async reset, active low
   input  wire logic start,     // Start pulse
   input  wire logic start_all, // Full store when high, single otherwise
   input  wire logic flash_ack, // Flash finished
   input  wire logic flash_err, // Flash failed, with ack
   output logic      flash_req, // Request held until ack
   output logic      busy,      // Store in progress
   output logic      busy_all,  // Full store in progress
   output logic      done,      // Success pulse
   output logic      fail       // Failure pulse
);
   pmsq_store_t s_q, s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.fail = 1'b0;
      case (s_q.st)
         PMSQ_ST_IDLE: begin
            if (start) begin
               s_d.st  = PMSQ_ST_REQ;
               s_d.all = start_all;
            end
         end
         PMSQ_ST_REQ: begin
            if (flash_ack) begin
               s_d.st   = PMSQ_ST_IDLE;
               s_d.done = !flash_err;
               s_d.fail = flash_err;
            end
         end
         default: s_d.st = PMSQ_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: PMSQ_ST_IDLE, all: 1'b0, done: 1'b0, fail: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign flash_req = (s_q.st == PMSQ_ST_REQ);
   assign busy      = flash_req;
   assign busy_all  = flash_req && s_q.all;
   assign done      = s_q.done;
   assign fail      = s_q.fail;
endmodule

// File: logic/pmsq_core.sv
// Purpose: Command handling for on/off gating, protection, fault clear and flash store
// Assumes: Commands arrive already framed from the serial interface
// Notes:   One command per cycle while cmd_ready is high
module pmsq_core
   import pmsq_pkg::*;
#(
   parameter int NFLT = `PMSQ_NFLT
) (
   input  wire logic            clk,               // System clock, 200 MHz
   input  wire logic            rst_b,             // Async reset, active low
   input  pmsq_cmd_t            cmd,               // Framed command in
   output logic                 cmd_ready,         // Command accepted this cycle
   output pmsq_resp_t           resp,              // Read answer, one cycle later
   input  wire logic            dual_sequence_flag,// Dual sequencing selected
   input  wire logic            alert_enable,      // Alert output allowed
   input  wire logic            control_pin,       // Raw CONTROL pin
   input  wire logic            bias_pin,          // Raw bias present level
   input  wire logic [NFLT-1:0] fault_in,          // Live fault and warning levels
   output logic      [NFLT-1:0] fault_status,      // Latched fault status
   output logic                 cml_status,        // CML bit of status word
   output logic                 alert_out,         // Alert request, active high
   output logic      [1:0]      supply_enable_out, // Sequence on: [0] primary, [1] secondary
   output logic      [1:0]      supply_fast_off,   // Off without delays, per sequence
   output logic      [7:0]      store_page,        // Page of single store
   output logic      [7:0]      store_code,        // Code of single store
   output logic                 store_all,         // Store kind of current request
   output logic                 flash_req,         // Flash request, held to ack
   input  wire logic            flash_ack,         // Flash finished
   input  wire logic            flash_err          // Flash failed, with ack
);
   // Status vector must fit one readback word
   if (NFLT < 1 || NFLT > 16) begin : g_nflt_check
      $error("NFLT must be 1 to 16");
   end

   typedef struct packed {
      logic [7:0]      page;
      logic [7:0]      op_pri;
      logic [7:0]      op_sec;
      logic [4:0]      onoff;
      logic [7:0]      wlock;
      logic [15:0]     single;
      logic [15:0]     pend;
      logic            pend_all;
      logic            cml;
      logic [NFLT-1:0] flt;
      logic [NFLT-1:0] flt_prev;
      logic            alert;
      logic [1:0]      seq_on;
      logic [1:0]      fast;
      logic            rd_valid;
      logic [15:0]     rd_data;
   } pmsq_core_st_t;

   pmsq_core_st_t r_q, r_d;

   logic [1:0] pins_s;
   logic       ctl_s;
   logic       bias_s;
   logic       st_busy;
   logic       st_busy_all;
   logic       st_done;
   logic       st_fail;
   logic       st_start;

   // Pins are asynchronous; two stages before any logic sees them
   pmsq_sync #(
      .W (2)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   ({bias_pin, control_pin}),
      .dout  (pins_s)
   );
   assign ctl_s  = pins_s[0];
   assign bias_s = pins_s[1];

   pmsq_store u_store (
      .clk       (clk),
      .rst_b     (rst_b),
      .start     (st_start),
      .start_all (r_d.pend_all),
      .flash_ack (flash_ack),
      .flash_err (flash_err),
      .flash_req (flash_req),
      .busy      (st_busy),
      .busy_all  (st_busy_all),
      .done      (st_done),
      .fail      (st_fail)
   );

   // Margin bytes count as standard on bytes here
   function automatic logic is_std_op(input logic [7:0] b);
      case (b)
         `PMSQ_OP_OFF_NOW, `PMSQ_OP_OFF_SOFT, `PMSQ_OP_ON,
         `PMSQ_OP_MLO_IGN, `PMSQ_OP_MLO_ACT,
         `PMSQ_OP_MHI_IGN, `PMSQ_OP_MHI_ACT: is_std_op = 1'b1;
         default:                             is_std_op = 1'b0;
      endcase
   endfunction

   // Base on/off byte of a special code, with the sequence bits dropped
   function automatic logic is_special(input logic [7:0] b);
      logic [7:0] base;
      base = {b[7:2], 2'b00};
      is_special = (b[1:0] == `PMSQ_OP_SEL_PRI || b[1:0] == `PMSQ_OP_SEL_SEC) &&
                   (base == `PMSQ_OP_OFF_NOW || base == `PMSQ_OP_OFF_SOFT ||
                    base == `PMSQ_OP_ON);
   endfunction

   // Clear and store are writes too, so a lock blocks them
   function automatic logic wr_allowed(input logic [7:0] lvl, input logic [7:0] code);
      case (lvl)
         `PMSQ_WL_ONLY_WL: wr_allowed = (code == `PMSQ_CMD_WLOCK);
         `PMSQ_WL_OP_PAGE: wr_allowed = (code == `PMSQ_CMD_WLOCK) ||
                                        (code == `PMSQ_CMD_OPER) ||
                                        (code == `PMSQ_CMD_PAGE);
         `PMSQ_WL_ONOFF:   wr_allowed = (code == `PMSQ_CMD_WLOCK) ||
                                        (code == `PMSQ_CMD_OPER) ||
                                        (code == `PMSQ_CMD_PAGE) ||
                                        (code == `PMSQ_CMD_ONOFF);
         default:          wr_allowed = 1'b1;
      endcase
   endfunction

   // Only the four listed lock levels exist; others are invalid data
   function automatic logic lock_known(input logic [7:0] lvl);
      lock_known = (lvl == `PMSQ_WL_ONLY_WL) || (lvl == `PMSQ_WL_OP_PAGE) ||
                   (lvl == `PMSQ_WL_ONOFF) || (lvl == `PMSQ_WL_NONE);
   endfunction

   // Turns one sequence's operation byte and the pin into on and fast-off
   function automatic logic [1:0] gate(input logic [4:0] cfg, input logic [7:0] op,
                                       input logic ctl, input logic bias);
      logic op_ok;
      logic ctl_act;
      logic ctl_ok;
      logic on;
      logic fast;
      ctl_act = cfg[`PMSQ_CFG_CTL_POL] ? ctl : !ctl;
      op_ok   = !cfg[`PMSQ_CFG_OP_EN] || op[`PMSQ_OP_ON_BIT];
      ctl_ok  = !cfg[`PMSQ_CFG_CTL_EN] || ctl_act;
      fast    = 1'b0;
      if (!cfg[`PMSQ_CFG_USE_CMD]) begin
         on = bias;
      end else begin
         on = op_ok && ctl_ok;
         if (!ctl_ok && cfg[`PMSQ_CFG_CTL_FAST]) begin
            fast = 1'b1;
         end
         if (!op_ok && !op[`PMSQ_OP_SOFT_BIT]) begin
            fast = 1'b1;
         end
      end
      gate = {fast, on};
   endfunction

   logic [NFLT-1:0] flt_rise;
   logic            clr;
   logic            bad_data;
   logic            wr_ok;
   logic            rd_take;
   logic            wr_take;
   logic [1:0]      g_pri;
   logic [1:0]      g_sec;

   always_comb begin
      r_d          = r_q;
      r_d.rd_valid = 1'b0;
      clr          = 1'b0;
      bad_data     = 1'b0;
      st_start     = 1'b0;
      // no commands during full store
      // Combinational so the very next command stalls
      cmd_ready    = !st_busy_all;
      wr_ok        = wr_allowed(r_q.wlock, cmd.code);
      rd_take      = cmd.valid && cmd_ready && !cmd.write;
      wr_take      = cmd.valid && cmd_ready && cmd.write;

      if (rd_take) begin
         r_d.rd_valid = 1'b1;
         case (cmd.code)
            `PMSQ_CMD_PAGE:   r_d.rd_data = {8'h00, r_q.page};
            `PMSQ_CMD_OPER:   r_d.rd_data = {8'h00, r_q.op_pri};
            `PMSQ_CMD_ONOFF:  r_d.rd_data = {11'h000, r_q.onoff};
            `PMSQ_CMD_WLOCK:  r_d.rd_data = {8'h00, r_q.wlock};
            `PMSQ_CMD_SINGLE: r_d.rd_data = r_q.single;
            // Write-only or unknown code read flags CML
            default: begin
               r_d.rd_data = 16'h0000;
               bad_data    = 1'b1;
            end
         endcase
      end

      if (wr_take && wr_ok) begin
         case (cmd.code)
            `PMSQ_CMD_PAGE: r_d.page = cmd.data[7:0];
            `PMSQ_CMD_OPER: begin
               if (is_std_op(cmd.data[7:0])) begin
                  r_d.op_pri = cmd.data[7:0];
                  r_d.op_sec = cmd.data[7:0];
               end else if (dual_sequence_flag && r_q.page == `PMSQ_PAGE_ALL &&
                            is_special(cmd.data[7:0])) begin
                  if (cmd.data[1:0] == `PMSQ_OP_SEL_PRI) begin
                     r_d.op_pri = {cmd.data[7:2], 2'b00};
                  end else begin
                     r_d.op_sec = {cmd.data[7:2], 2'b00};
                  end
               end else begin
                  bad_data = 1'b1;
               end
            end
            `PMSQ_CMD_ONOFF: r_d.onoff = cmd.data[4:0];
            `PMSQ_CMD_WLOCK: begin
               if (lock_known(cmd.data[7:0])) begin
                  r_d.wlock = cmd.data[7:0];
               end else begin
                  bad_data = 1'b1;
               end
            end
            `PMSQ_CMD_CLRF: clr = 1'b1;
            `PMSQ_CMD_STALL: begin
               if (!st_busy) begin
                  r_d.pend_all = 1'b1;
                  st_start     = 1'b1;
               end
            end
            `PMSQ_CMD_SINGLE: begin
               if (!st_busy) begin
                  // Pair shown on store outputs while flash works
                  r_d.pend     = cmd.data;
                  r_d.pend_all = 1'b0;
                  st_start     = 1'b1;
               end
            end
            default: bad_data = 1'b1;
         endcase
      end

      if (st_done && !r_q.pend_all) begin
         r_d.single = r_q.pend;
      end

      // monitoring frozen during full store
      // Edge memory held so a store cannot fake new faults
      flt_rise = '0;
      if (!st_busy_all) begin
         flt_rise     = fault_in & ~r_q.flt_prev;
         r_d.flt_prev = fault_in;
      end

      // one-step clear of status and alert
      if (clr) begin
         r_d.cml   = 1'b0;
         r_d.alert = 1'b0;
         r_d.flt   = st_busy_all ? '0 : fault_in;
      end else if (!st_busy_all) begin
         r_d.flt = r_q.flt | fault_in;
      end

      // Set wins over clear for new events
      // failed store marks CML and, when alert_enable, the alert
      if (bad_data || st_fail) begin
         r_d.cml = 1'b1;
      end
      if ((bad_data || st_fail || (|flt_rise)) && alert_enable) begin
         r_d.alert = 1'b1;
      end

      // enables follow on/off config, operation, pin and bias
      g_pri      = gate(r_q.onoff, r_q.op_pri, ctl_s, bias_s);
      // Secondary follows the primary byte unless in dual mode
      g_sec      = gate(r_q.onoff, dual_sequence_flag ? r_q.op_sec : r_q.op_pri,
                        ctl_s, bias_s);
      r_d.seq_on = {g_sec[0], g_pri[0]};
      r_d.fast   = {g_sec[1], g_pri[1]};
   end

   // Gating has a non-zero power-on value; lock resets to none
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_q          <= '0;
         r_q.onoff    <= `PMSQ_ONOFF_RST;
         r_q.wlock    <= `PMSQ_WLOCK_RST;
      end else begin
         r_q <= r_d;
      end
   end

   assign resp              = '{valid: r_q.rd_valid, data: r_q.rd_data};
   assign fault_status      = r_q.flt;
   assign cml_status        = r_q.cml;
   assign alert_out         = r_q.alert;
   assign supply_enable_out = r_q.seq_on;
   assign supply_fast_off   = r_q.fast;
   assign store_page        = r_q.pend[15:8];
   assign store_code        = r_q.pend[7:0];
   assign store_all         = r_q.pend_all;
endmodule

// File: testbench/pmsq_core_monitor.sv
// Purpose: Port checker for the supply command block
// Assumes: One clock, async active-low reset
// Notes:   Bound into every pmsq_core instance
module pmsq_core_monitor
   import pmsq_pkg::*;
#(
   parameter int NFLT = 8
) (
   input  wire logic            clk,               // Clock
   input  wire logic            rst_b,             // Reset, active low
   input  pmsq_cmd_t            cmd,               // Command in
   input  wire logic            cmd_ready,         // Command taken
   input  pmsq_resp_t           resp,              // Read answer
   input  wire logic            alert_enable,      // Alert allowed
   input  wire logic            control_pin,       // Raw control pin
   input  wire logic            bias_pin,          // Raw bias level
   input  wire logic [NFLT-1:0] fault_in,          // Live faults
   input  wire logic [NFLT-1:0] fault_status,      // Latched faults
   input  wire logic            cml_status,        // CML bit
   input  wire logic            alert_out,         // Alert request
   input  wire logic [1:0]      supply_enable_out, // Sequence enables
   input  wire logic [7:0]      store_page,        // Store page
   input  wire logic [7:0]      store_code,        // Store code
   input  wire logic            store_all,         // Full store kind
   input  wire logic            flash_req,         // Flash request
   input  wire logic            flash_ack,         // Flash done
   input  wire logic            flash_err          // Flash failed
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   wire logic take = cmd.valid && cmd_ready;
   wire logic rd   = take && !cmd.write;
   wire logic clr  = take && cmd.write && cmd.code == 8'h03;
   wire logic st   = take && cmd.write && (cmd.code == 8'h11 || cmd.code == 8'hfc);

   a_read_answered: assert property (rd |=> resp.valid)
      else $error("read not answered");
   a_op_read_std: assert property (rd && cmd.code == 8'h01 |=> resp.data[1:0] == 2'b00)
      else $error("operation read gave a special code");
   a_gate_rsvd_zero: assert property (rd && cmd.code == 8'h02 |=> resp.data[15:5] == '0)
      else $error("gating upper bits not zero");
   a_clear_drop_alert: assert property (clr && $stable(fault_in) && !$past(flash_ack)
      |=> !alert_out)
      else $error("alert kept after fault clear");
   a_clear_relatch: assert property (clr |=> fault_status == $past(fault_in))
      else $error("status after clear differs from live faults");
   a_clear_keep_en: assert property (
      ($stable(control_pin) && $stable(bias_pin))[*4] ##0 clr |=> $stable(supply_enable_out))
      else $error("fault clear moved supply enables");
   a_store_start: assert property (
      st && !flash_req && !$past(flash_req) |=> flash_req
      && store_all == ($past(cmd.code) == 8'h11))
      else $error("store request not raised");
   a_single_pair: assert property (
      st && !flash_req && !$past(flash_req) && cmd.code == 8'hfc
      |=> {store_page, store_code} == $past(cmd.data))
      else $error("single store pair wrong");
   a_full_mute: assert property (flash_req && store_all |-> !cmd_ready)
      else $error("commands taken during full store");
   a_req_hold: assert property (flash_req && !flash_ack |=> flash_req)
      else $error("flash request dropped before ack");
   a_fail_flags: assert property (
      flash_req && flash_ack && flash_err
      |=> ##1 cml_status && (alert_out || !$past(alert_enable)))
      else $error("store failure not flagged");
endmodule

bind pmsq_core pmsq_core_monitor #(.NFLT(NFLT)) u_mon (.*);

// File: testbench/pmsq_host.sv
// Purpose: Command host model for the supply command block
// Assumes: Drives at the falling edge, holds until taken
// Notes:   Task send is called from the bench
module pmsq_host
   import pmsq_pkg::*;
(
   input  wire logic clk,       // Clock
   output pmsq_cmd_t  cmd,       // Command out
   input  wire logic cmd_ready, // Taken when high
   input  pmsq_resp_t resp       // Read answer
);
   timeunit 1ns;
   timeprecision 100ps;
   int stores;

   initial begin
      cmd = '0;
   end

   task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output bit ok);
      int n;
      ok = 1'b0;
      if (w && c == 8'hfc) begin
         if (stores >= 85) return;
         stores++;
      end
      @(negedge clk);
      cmd = '{1'b1, w, c, d};
      for (n = 0; n < 200; n++) begin
         #1;
         ok = (cmd_ready === 1'b1);
         @(posedge clk);
         if (ok) break;
         @(negedge clk);
      end
      @(negedge clk);
      cmd = '{1'b0, 1'b0, 8'h00, ~d};
   endtask
endmodule

// File: testbench/pmsq_core_tb.sv
// Purpose: Self-checking bench for the supply command block
// Assumes: 200 MHz clock, inputs change at falling edge
// Notes:   Flash side answered by a small responder here
module pmsq_core_tb
   import pmsq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk, rst_b, cmd_ready, dual_sequence_flag, alert_enable, control_pin;
   logic       bias_pin, cml_status, alert_out, store_all, flash_req;
   logic       flash_ack = 1'b0;
   logic       flash_err = 1'b0;
   logic [7:0] fault_in, fault_status, store_page, store_code;
   logic [1:0] supply_enable_out, supply_fast_off;
   pmsq_cmd_t  cmd;
   pmsq_resp_t resp;
   int         mismatches, checked, fl_delay, fl_cnt;
   logic       fl_err;
   // cfg, op, ctl, bias, enables, fast-off, fast-off checked
   localparam logic [35:0] ROWS [14] = '{36'h1e8010300, 36'h1e8000001, 36'h1f8010300,
      36'h1f8000031, 36'h1e0010031, 36'h1e4010000, 36'h1c8000300, 36'h1c8010000,
      36'h188000300, 36'h180010031, 36'h160010300, 36'h168000001, 36'h000001300, 36'h0};
   // op byte, enables, readback
   localparam logic [19:0] DUAL [10] = '{20'h80380, 20'h01200, 20'h81380, 20'h42180,
      20'h02180, 20'h82380, 20'h41240, 20'h80380, 20'h94394, 20'h00000};
   localparam logic [7:0] LOCKS [4] = '{8'h80, 8'h40, 8'h20, 8'h00};

   pmsq_core dut (.*);
   pmsq_host u_host (.clk(clk), .cmd(cmd), .cmd_ready(cmd_ready), .resp(resp));

   always #2.5 clk = ~clk;

   // Flash responder; err line toggles when not meaningful
   always @(negedge clk) begin
      if (flash_req === 1'b1 && !flash_ack && fl_cnt >= fl_delay) begin
         flash_ack <= 1'b1;
         flash_err <= fl_err;
         fl_cnt <= 0;
      end else begin
         flash_ack <= 1'b0;
         flash_err <= ~flash_err;
         if (flash_req === 1'b1 && !flash_ack)
            fl_cnt <= fl_cnt + 1;
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d = 16'h0000);
      bit ok;
      u_host.send(1'b1, c, d, ok);
      if (!ok) begin
         mismatches++;
         test_done();
      end
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      bit ok;
      u_host.send(1'b0, c, 16'h0000, ok);
      check($sformatf("read %h", c), (ok && resp.valid === 1'b1) ? resp.data : 16'hxxxx, exp);
   endtask

   task automatic flash_wait();
      int n;
      for (n = 0; n < 50 && flash_req !== 1'b0; n++) @(negedge clk);
      if (n == 50) begin
         mismatches++;
         test_done();
      end
      idle(1);
   endtask

   task automatic t_reset();
      rd(8'h02, 16'h001e);
      rd(8'h10, 16'h0000);
      rd(8'hfc, 16'h0000);
      wr(8'h02, 16'h00ff);
      rd(8'h02, 16'h001f);
   endtask

   task automatic t_gating();
      foreach (ROWS[i]) begin
         wr(8'h02, {8'h00, ROWS[i][35:28]});
         control_pin = ROWS[i][16];
         bias_pin = ROWS[i][12];
         wr(8'h01, {8'h00, ROWS[i][27:20]});
         idle(6);
         check("enable", {14'h0, supply_enable_out}, {14'h0, ROWS[i][9:8]});
         if (ROWS[i][0])
            check("fast off", {14'h0, supply_fast_off}, {14'h0, ROWS[i][5:4]});
      end
   endtask

   task automatic t_dual();
      dual_sequence_flag = 1'b1;
      control_pin = 1'b1;
      wr(8'h02, 16'h001e);
      wr(8'h01, 16'h0080);
      wr(8'h01, 16'h0001);
      idle(3);
      check("special off page", {14'h0, supply_enable_out}, 16'h0003);
      check("special refused", {15'h0, cml_status}, 16'h0001);
      wr(8'h03);
      wr(8'h00, 16'h00ff);
      foreach (DUAL[i]) begin
         wr(8'h01, {8'h00, DUAL[i][19:12]});
         idle(3);
         check("dual enable", {14'h0, supply_enable_out}, {14'h0, DUAL[i][9:8]});
         rd(8'h01, {8'h00, DUAL[i][7:0]});
      end
      wr(8'h00, 16'h0000);
      dual_sequence_flag = 1'b0;
   endtask

   task automatic t_faults();
      wr(8'h01, 16'h0080);
      fault_in = 8'h05;
      idle(3);
      check("alert set", {7'h0, alert_out, fault_status}, 16'h0105);
      wr(8'h03);
      check("status kept", {7'h0, alert_out, fault_status}, 16'h0005);
      check("enable kept", {14'h0, supply_enable_out}, 16'h0003);
      idle(3);
      check("alert quiet", {15'h0, alert_out}, 16'h0000);
      fault_in = 8'h07;
      idle(3);
      check("new fault", {15'h0, alert_out}, 16'h0001);
      fault_in = 8'h00;
      wr(8'h03);
      check("all clear", {6'h0, cml_status, alert_out, fault_status}, 16'h0000);
      alert_enable = 1'b0;
      wr(8'h10, 16'h0033);
      check("masked alert", {14'h0, cml_status, alert_out}, 16'h0002);
      rd(8'h10, 16'h0000);
      alert_enable = 1'b1;
      wr(8'h03);
   endtask

   task automatic t_lock();
      foreach (LOCKS[i]) begin
         wr(8'h10, 16'h0000);
         wr(8'h02, 16'h001e);
         wr(8'h01, 16'h0000);
         wr(8'h10, {8'h00, LOCKS[i]});
         wr(8'h02, 16'h001c);
         wr(8'h01, 16'h0040);
         rd(8'h02, LOCKS[i][7:6] != 2'b00 ? 16'h001e : 16'h001c);
         rd(8'h01, LOCKS[i][7] ? 16'h0000 : 16'h0040);
         rd(8'h10, {8'h00, LOCKS[i]});
         check("silent drop", {15'h0, cml_status}, 16'h0000);
      end
      wr(8'h02, 16'h001e);
   endtask

   task automatic t_store();
      wr(8'hfc, 16'h0460);
      check("single req", {14'h0, flash_req, store_all}, 16'h0002);
      check("single pair", {store_page, store_code}, 16'h0460);
      flash_wait();
      rd(8'hfc, 16'h0460);
      fl_err = 1'b1;
      wr(8'hfc, 16'h0511);
      flash_wait();
      check("single fail", {14'h0, cml_status, alert_out}, 16'h0003);
      rd(8'hfc, 16'h0460);
      wr(8'h03);
      fl_delay = 6;
      wr(8'h11);
      check("full busy", {14'h0, store_all, cmd_ready}, 16'h0002);
      flash_wait();
      check("full fail", {14'h0, cml_status, alert_out}, 16'h0003);
      wr(8'h03);
      fl_err = 1'b0;
      wr(8'h11);
      flash_wait();
      check("full ok", {14'h0, cml_status, alert_out}, 16'h0000);
      rd(8'h02, 16'h001e);
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      dual_sequence_flag = 1'b0;
      alert_enable = 1'b1;
      control_pin = 1'b0;
      bias_pin = 1'b0;
      fault_in = 8'h00;
      fl_delay = 2;
      fl_err = 1'b0;
      mismatches = 0;
      checked = 0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_gating();
      t_dual();
      t_faults();
      t_lock();
      t_store();
      test_done();
   end
endmodule
